// ===== hw/sys_event_defines.vh
// Constants for the system event, mask, status, enable and delay register group.
`ifndef SYS_EVENT_DEFINES_VH
`define SYS_EVENT_DEFINES_VH

// ==========================================================================
// Register indexes; the byte address is four times the index.
`define IDX_INT_SOURCE 6'h01
`define IDX_FLAGS 6'h03
`define IDX_MASK 6'h04
`define IDX_STATUS 6'h05
`define IDX_EN_CTRL 6'h06
`define IDX_START_DLY 6'h07

// ==========================================================================
// Reset values.
`define RST_FLAGS 5'h00
`define RST_MASK 5'h13
`define RST_EN_CTRL 8'h00
`define RST_DLY_FIELD 5'h00
`define RST_DLY_UNIT 1'b0

// ==========================================================================
// Field positions.
`define FLAG_WDT 4
`define FLAG_UV 3
`define FLAG_TSD 2
`define FLAG_HOT_HIGH 1
`define FLAG_HOT_LOW 0
`define NUM_FLAGS 5
`define DLY_UNIT_BIT 7
`define DLY_FIELD_MSB 4
`define INT_SRC_SYS_BIT 0

// ==========================================================================
// Timing: one delay unit of 1 ms at a 50 MHz clock.
`define CLK_MHZ 50
`define UNIT_US 1000
`define UNIT_CYCLES (`UNIT_US * `CLK_MHZ)

`endif

// ===== hw/start_delay_timer.v
// Startup delay timer that releases one output after a counted delay.
`timescale 1ns/1ps

module start_delay_timer #(
	parameter UNIT_CYCLES = 50000
) (
	// Clock and reset.
	input wire clk,
	input wire reset_n,
	// Request and settings.
	input wire request,
	input wire [4:0] steps,
	input wire unit_double,
	// Result.
	output reg started
);

	reg request_d_r;
	reg running_r;
	reg [5:0] units_left_r;
	reg [16:0] prescale_r;
	wire request_rise;
	wire [5:0] units_total;
	wire unit_tick;

	// A rising request starts the count; 2 ms steps count two units each.
	assign request_rise = request & ~request_d_r;
	assign units_total = unit_double ? {steps, 1'b0} : {1'b0, steps};
	assign unit_tick = (prescale_r == UNIT_CYCLES[16:0] - 17'd1);

	// The prescaler restarts on the request so the first unit is whole.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			request_d_r <= 1'b0;
			running_r <= 1'b0;
			units_left_r <= 6'h00;
			prescale_r <= 17'h00000;
			started <= 1'b0;
		end else begin
			request_d_r <= request;
			if (!request) begin
				running_r <= 1'b0;
				started <= 1'b0;
			end else if (request_rise) begin
				prescale_r <= 17'h00000;
				units_left_r <= units_total;
				running_r <= (units_total != 6'h00);
				started <= (units_total == 6'h00);
			end else if (running_r) begin
				prescale_r <= unit_tick ? 17'h00000 : prescale_r + 17'd1;
				if (unit_tick) begin
					units_left_r <= units_left_r - 6'd1;
					if (units_left_r == 6'd1) begin
						running_r <= 1'b0;
						started <= 1'b1;
					end
				end
			end
		end
	end

endmodule

// ===== hw/sys_event_enable_regs.v
// System event, mask, status, enable and startup delay registers on APB.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "sys_event_defines.vh"

module sys_event_enable_regs #(
	parameter UNIT_CYCLES = `UNIT_CYCLES
) (
	// Clock and reset.
	input wire clk,
	input wire reset_n,
	// APB slave.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Pins and live conditions, all asynchronous.
	input wire watchdog_reset_input_pin_n,
	input wire undervoltage_now,
	input wire thermal_shutdown_now,
	input wire hot_high_now,
	input wire hot_low_now,
	input wire [3:0] general_input_pin,
	input wire global_turn_on,
	// Regulator controls.
	output reg [3:0] master_output_on,
	output reg [3:0] master_low_power_sel,
	output wire master2_start,
	// Interrupt request, active high level.
	output reg irq
);

	// ======================================================================
	// Input synchronisers.
	localparam NSYNC = 10;
	wire [NSYNC-1:0] raw_in;
	reg [NSYNC-1:0] sync1_r;
	reg [NSYNC-1:0] sync2_r;
	reg [`NUM_FLAGS-1:0] prev_r;

	// The watchdog pin is inverted first so that every bit is active high
	// and one rising-edge detector serves all five events.
	assign raw_in = {global_turn_on, general_input_pin, ~watchdog_reset_input_pin_n,
		undervoltage_now, thermal_shutdown_now, hot_high_now, hot_low_now};

	// Each input passes two flip-flops before any logic reads it.
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= raw_in[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	// A third copy of the event condition bits feeds edge detection.
	// Only the second flip-flop is read, so no unsettled value reaches logic.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_r <= `RST_FLAGS;
		end else begin
			prev_r <= sync2_r[`NUM_FLAGS-1:0];
		end
	end

	// Named views of the synchronised inputs.
	// Bit positions follow raw_in above; keep the two in step.
	wire hot_low_s;
	wire hot_high_s;
	wire tsd_s;
	wire uv_s;
	wire wdt_active_s;
	wire [3:0] gpi_s;
	wire global_s;

	assign hot_low_s = sync2_r[0];
	assign hot_high_s = sync2_r[1];
	assign tsd_s = sync2_r[2];
	assign uv_s = sync2_r[3];
	assign wdt_active_s = sync2_r[4];
	assign gpi_s = sync2_r[8:5];
	assign global_s = sync2_r[9];

	// ======================================================================
	// Event detection.
	wire [`NUM_FLAGS-1:0] cond_now;
	wire [`NUM_FLAGS-1:0] cond_prev;
	wire [`NUM_FLAGS-1:0] event_set;

	// Flag order matches the flag register layout.
	assign cond_now = sync2_r[4:0];
	assign cond_prev = prev_r[4:0];

	// A flag sets only when its condition enters the active state.
	// The two heat warnings have separate edges and never share one.
	assign event_set = cond_now & ~cond_prev;

	// ======================================================================
	// APB decode.
	wire [5:0] idx;
	wire addr_ok;
	wire setup_phase;
	wire access_phase;
	wire wr_access;
	wire rd_setup;

	// Misaligned addresses are refused as unmapped, so a stray byte address
	// can never reach a register by accident.
	assign idx = paddr[7:2];
	assign addr_ok = (paddr[1:0] == 2'b00) &&
		((idx == `IDX_INT_SOURCE) || (idx == `IDX_FLAGS) ||
		(idx == `IDX_MASK) || (idx == `IDX_STATUS) ||
		(idx == `IDX_EN_CTRL) || (idx == `IDX_START_DLY));
	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	assign wr_access = access_phase & pwrite & addr_ok;
	assign rd_setup = setup_phase & ~pwrite;

	// The slave never inserts wait states; unmapped addresses answer with an error.
	assign pready = 1'b1;
	assign pslverr = access_phase & ~addr_ok;

	// ======================================================================
	// Registers.
	reg [`NUM_FLAGS-1:0] flags_r;
	reg [`NUM_FLAGS-1:0] flags_nxt;
	reg [`NUM_FLAGS-1:0] mask_r;
	reg [7:0] en_ctrl_r;
	reg dly_unit_r;
	reg [`DLY_FIELD_MSB:0] m2_dly_r;
	reg [`NUM_FLAGS-1:0] rd_clear_r;
	reg rd_clear_pending_r;
	wire [`NUM_FLAGS-1:0] unmasked;
	wire sys_event_pending;

	// Only flags that were sampled into read data are cleared by that read,
	// so an event arriving between setup and access phases is never lost.
	always @* begin
		flags_nxt = flags_r;
		if (rd_clear_pending_r && access_phase && !pwrite) begin
			flags_nxt = flags_nxt & ~rd_clear_r;
		end
		// The set is applied after the clear, so an event in the clearing
		// cycle survives and is seen by the next read.
		flags_nxt = flags_nxt | event_set;
	end

	// Event flags, cleared by reading them.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_r <= `RST_FLAGS;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// Mask register with the same layout as the flags.
	// The unused upper bits are not stored and read back as zero.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_r <= `RST_MASK;
		end else if (wr_access && idx == `IDX_MASK) begin
			mask_r <= pwdata[`NUM_FLAGS-1:0];
		end
	end

	// Enable control register.
	// All eight bits are stored; none of them is reserved.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en_ctrl_r <= `RST_EN_CTRL;
		end else if (wr_access && idx == `IDX_EN_CTRL) begin
			en_ctrl_r <= pwdata[7:0];
		end
	end

	// First startup delay register: unit select and master 2 field.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dly_unit_r <= `RST_DLY_UNIT;
			m2_dly_r <= `RST_DLY_FIELD;
		end else if (wr_access && idx == `IDX_START_DLY) begin
			dly_unit_r <= pwdata[`DLY_UNIT_BIT];
			m2_dly_r <= pwdata[`DLY_FIELD_MSB:0];
		end
	end

	// ======================================================================
	// Interrupt.
	// Mask bit zero lets a flag through, one blocks it.
	assign unmasked = flags_r & ~mask_r;
	assign sys_event_pending = |unmasked;

	// The request output follows the unmasked flags as a level.
	// Using the next flag value lets the request drop on the same edge
	// as the clearing read instead of one cycle after it.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags_nxt & ~mask_r);
		end
	end

	// ======================================================================
	// Read data.
	reg [31:0] rd_mux;

	// Read data are chosen in the setup phase and held through the access.
	// Status bits are the synchronised levels, two cycles behind the pins,
	// and they are never latched.
	always @* begin
		rd_mux = 32'h00000000;
		case (idx)
			`IDX_INT_SOURCE: rd_mux[`INT_SRC_SYS_BIT] = sys_event_pending;
			`IDX_FLAGS: rd_mux[`NUM_FLAGS-1:0] = flags_r;
			`IDX_MASK: rd_mux[`NUM_FLAGS-1:0] = mask_r;
			`IDX_STATUS: rd_mux[3:0] = {uv_s, tsd_s, hot_high_s, hot_low_s};
			`IDX_EN_CTRL: rd_mux[7:0] = en_ctrl_r;
			`IDX_START_DLY: begin
				rd_mux[`DLY_UNIT_BIT] = dly_unit_r;
				rd_mux[`DLY_FIELD_MSB:0] = m2_dly_r;
			end
			default: rd_mux = 32'h00000000;
		endcase
		if (paddr[1:0] != 2'b00) begin
			rd_mux = 32'h00000000;
		end
	end

	// Capture read data and note which flags this read may clear.
	// A read of any other register leaves the pending clear off, so only
	// a read of the flag register can clear flags.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h00000000;
			rd_clear_r <= `RST_FLAGS;
			rd_clear_pending_r <= 1'b0;
		end else if (rd_setup) begin
			prdata <= rd_mux;
			rd_clear_pending_r <= addr_ok && (idx == `IDX_FLAGS);
			rd_clear_r <= flags_r;
		end else if (access_phase) begin
			rd_clear_pending_r <= 1'b0;
		end
	end

	// ======================================================================
	// Regulator enables and low power selects.
	wire [3:0] eff_on;
	wire [3:0] lpm_sel;

	// Even bits enable masters 1 to 4, odd bits pick low power mode.
	// A general input can turn a master on but never off, so software
	// cannot override a pin that is held high.
	genvar mi;
	generate
		for (mi = 0; mi < 4; mi = mi + 1) begin : g_master
			assign eff_on[mi] = en_ctrl_r[2*mi] | gpi_s[mi];
			assign lpm_sel[mi] = en_ctrl_r[2*mi+1];
		end
	endgenerate

	// Drive the regulator controls from flip-flops.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			master_output_on <= 4'h0;
			master_low_power_sel <= 4'h0;
		end else begin
			master_output_on <= eff_on;
			master_low_power_sel <= lpm_sel;
		end
	end

	// ======================================================================
	// Master 2 startup delay.
	// The count starts on a rising edge of master 2's enable ORed with the global enable.
	wire m2_request;

	// The delay counts from the synchronised request, so the output starts
	// about three clock cycles later than the field alone would give.
	assign m2_request = eff_on[1] | global_s;

	// The timer sees the same unit and field that software reads back.
	start_delay_timer #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) start_delay_timer_inst (
		.clk(clk),
		.reset_n(reset_n),
		.request(m2_request),
		.steps(m2_dly_r),
		.unit_double(dly_unit_r),
		.started(master2_start)
	);

endmodule

// ===== tb/sys_event_enable_regs_chk.sv
// Checker of the bus answers, read data and interrupt of the register group.
`timescale 1ns/1ps
module sys_event_enable_regs_chk (
	// Clock and reset.
	input wire clk,
	input wire reset_n,
	// Bus.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Controls.
	input wire [3:0] master_low_power_sel,
	input wire irq
);
	// Decode of the current access; clr marks a flag read or a mask write.
	wire [5:0] x = paddr[7:2];
	wire acc = psel && penable;
	wire ok = paddr[1:0] == 2'h0 && x != 6'h0 && x != 6'h2 && x < 6'h8;
	wire rdc = acc && !pwrite;
	wire clr = rdc && paddr == 8'h0c || acc && pwrite && paddr == 8'h10;
	wire [3:0] lpw = {pwdata[7], pwdata[5], pwdata[3], pwdata[1]};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// A write of the enable control register.
	sequence en_write;
		acc && pwrite && paddr == 8'h18;
	endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_bad_err: assert property (acc && !ok |-> pslverr) else $error("no error");
	a_data_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("prdata moved");
	a_bad_zero: assert property (rdc && !ok |-> prdata == 32'h0) else $error("bad read data");
	a_upper_zero: assert property (rdc |-> prdata[31:8] == 24'h0) else $error("upper bits set");
	a_flag_resv: assert property (rdc && paddr == 8'h0c |-> prdata[7:5] == 3'h0)
		else $error("flag reserved set");
	a_irq_fall: assert property ($fell(irq) |-> $past(clr) || $past(clr, 2))
		else $error("irq fell alone");
	a_lp_follow: assert property (en_write |-> ##2 master_low_power_sel == $past(lpw, 2))
		else $error("low power wrong");
endmodule
bind sys_event_enable_regs sys_event_enable_regs_chk chk_inst (.*);

// ===== tb/sys_event_enable_regs_test.sv
// Self-checking bench of the system event and enable register group.
`timescale 1ns/1ps
module sys_event_enable_regs_test;
	// ==========
	// Signals.
	reg clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, glob = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, rd, d, g;
	reg [4:0] cond = 5'h00;
	reg [3:0] gpi = 4'h0;
	reg err;
	wire [31:0] prdata;
	wire pready, pslverr, m2, irq;
	wire [3:0] on, lp;
	integer miscompares = 0, checks = 0, i, n, e;
	// Device with a ten-cycle delay unit.
	sys_event_enable_regs #(.UNIT_CYCLES(10)) sys_event_enable_regs_inst (
		.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.watchdog_reset_input_pin_n(!cond[4]), .undervoltage_now(cond[3]),
		.thermal_shutdown_now(cond[2]), .hot_high_now(cond[1]), .hot_low_now(cond[0]),
		.general_input_pin(gpi), .global_turn_on(glob), .master_output_on(on),
		.master_low_power_sel(lp), .master2_start(m2), .irq(irq));
	// Clock of 20 ns.
	initial begin
		forever #10 clk = ~clk;
	end
	// ==========
	// Tasks.
	// Prints the counts and the verdict, then ends the run.
	task stop_test;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Compares a value and counts a mismatch.
	task chk(input [31:0] got, input [31:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One bus transfer; read data and error are taken at the pready edge.
	task apb(input w, input [7:0] a, input [31:0] wd);
		integer k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		@(posedge clk);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge clk);
			k = k + 1;
		end
		if (k == 20) begin
			miscompares = miscompares + 1;
			stop_test;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Gathers the even or odd bits of the enable control value.
	function [3:0] pick(input [7:0] v, input integer o);
		pick = {v[6 + o], v[4 + o], v[2 + o], v[o]};
	endfunction
	// ==========
	// Main sequence.
	initial begin
		i = $urandom(67972);
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		for (i = 0; i < 5; i = i + 1) begin
			apb(1'b0, 8'h0c + {i[5:0], 2'b00}, 0);
			chk(rd, i == 1 ? 32'h13 : 32'h0);
		end
		apb(1'b1, 8'h08, 32'hff);
		apb(1'b0, 8'h08, 0);
		chk(rd, 0);
		apb(1'b0, 8'h11, 0);
		chk({31'h0, err}, 1);
		apb(1'b1, 8'h0c, 32'h1f);
		apb(1'b0, 8'h0c, 0);
		chk(rd, 0);
		$display("reset and map done");
		// Each event alone, with the reset mask.
		for (i = 0; i < 5; i = i + 1) begin
			cond <= 5'h01 << i;
			repeat (6) @(posedge clk);
			e = ((5'h01 << i) & 5'h0c) != 0;
			chk({31'h0, irq}, e);
			apb(1'b0, 8'h04, 0);
			chk(rd, e);
			apb(1'b0, 8'h14, 0);
			chk(rd, (32'h1 << i) & 32'hf);
			apb(1'b0, 8'h0c, 0);
			chk(rd, 32'h1 << i);
			repeat (4) @(posedge clk);
			apb(1'b0, 8'h0c, 0);
			chk(rd, 0);
			chk({31'h0, irq}, 0);
			cond <= 5'h00;
			repeat (6) @(posedge clk);
		end
		$display("flags done");
		apb(1'b1, 8'h10, 32'h0);
		apb(1'b0, 8'h10, 0);
		chk(rd, 0);
		cond <= 5'h13;
		repeat (6) @(posedge clk);
		chk({31'h0, irq}, 1);
		apb(1'b1, 8'h10, 32'h13);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 0);
		apb(1'b0, 8'h0c, 0);
		chk(rd, 32'h13);
		cond <= 5'h00;
		$display("mask done");
		// Enable bits against random general inputs.
		for (i = 0; i < 8; i = i + 1) begin
			d = i == 0 ? 32'h55 : i == 1 ? 32'haa : $urandom & 32'hff;
			g = i < 2 ? 32'h0 : $urandom;
			gpi <= g[3:0];
			apb(1'b1, 8'h18, d);
			apb(1'b0, 8'h18, 0);
			chk(rd, d);
			repeat (5) @(posedge clk);
			chk({28'h0, on}, {28'h0, pick(d[7:0], 0) | g[3:0]});
			chk({28'h0, lp}, {28'h0, pick(d[7:0], 1)});
		end
		gpi <= 4'h0;
		apb(1'b1, 8'h18, 0);
		$display("enables done");
		// Master 2 delay for both units and the field ends.
		for (i = 0; i < 4; i = i + 1) begin
			d = i == 0 ? 32'h00 : i == 1 ? 32'h81 : i == 2 ? 32'h9f : 32'h07;
			apb(1'b1, 8'h1c, d);
			apb(1'b0, 8'h1c, 0);
			chk(rd, d);
			e = d[4:0] * (d[7] ? 20 : 10);
			glob <= 1'b1;
			n = 0;
			while (m2 !== 1'b1 && n < 1000) begin
				@(posedge clk);
				n = n + 1;
			end
			if (n == 1000) begin
				miscompares = miscompares + 1;
				stop_test;
			end
			chk(n > e && n < e + 9, 1);
			glob <= 1'b0;
			repeat (5) @(posedge clk);
		end
		$display("delay done");
		stop_test;
	end
endmodule
